// [tb_two_wire_bus_control.sv]
// bench for the two-wire bus control block
// assumes the bus model is compiled first; hready is the slave's hreadyout
`timescale 1ns/1ps
`default_nettype none
module tb_two_wire_bus_control
   import tbc_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic chip_idle = 1'b0;
   logic slave_tx_start = 1'b0;
   logic rx_go = 1'b0;
   logic hreadyout, hresp, scl_oe_n, sda_oe_n, pins_owned, sda_drv_n;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic [7:0] rx_byte;
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0;
   int sda_lows = 0;
   wire logic scl;
   wire logic sda;
   assign scl = scl_oe_n;
   assign sda = sda_oe_n & sda_drv_n;
   always #4 hclk = ~hclk;
   tbc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .chip_idle(chip_idle), .slave_tx_start(slave_tx_start), .scl_in(scl),
      .sda_in(sda), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
      .pins_owned(pins_owned), .rx_byte(rx_byte));
   tbc_bus_model model (.scl(scl), .active(rx_go), .sda_drv_n(sda_drv_n));
   // count cycles where the block pulls data low
   always @(negedge hclk)
   begin
      if (sda_oe_n === 1'b0) sda_lows++;
   end
   // cut a hang short
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // one single transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : bus
   // poll the control word until trigger bit b drops
   task automatic wait_clr(input int b);
      int i;
      i = 0;
      bus(1'b0, CTRL_OFFSET, 32'h0);
      while (rd[b] === 1'b1 && i < 80)
      begin
         bus(1'b0, CTRL_OFFSET, 32'h0);
         i++;
      end
      chk("trigger clear", 32'h0, {31'h0, rd[b]});
   endtask : wait_clr
   task automatic trig(input logic [15:0] v, input int b);
      bus(1'b1, CTRL_OFFSET, {16'h0, v});
      bus(1'b0, CTRL_OFFSET, 32'h0);
      chk("trigger set", 32'h1, {31'h0, rd[b]});
      wait_clr(b);
   endtask : trig
   task automatic t_regs();
      bus(1'b0, CTRL_OFFSET, 32'h0);
      chk("ctrl reset", {16'h0, CTRL_RESET}, rd);
      bus(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, rd);
      chk("okay resp", 32'h0, {31'h0, hresp});
      bus(1'b1, CTRL_OFFSET, 32'hFFFF4000);
      bus(1'b0, CTRL_OFFSET, 32'h0);
      chk("bit14", 32'h0, rd);
      chk("owned off", 32'h0, {31'h0, pins_owned});
      bus(1'b1, CTRL_OFFSET, 32'h9000);
      @(posedge hclk);
      chk("owned on", 32'h1, {31'h0, pins_owned});
   endtask : t_regs
   task automatic t_seq();
      int n;
      trig(16'h9001, 0);
      trig(16'h9002, 1);
      trig(16'h9004, 2);
      n = sda_lows;
      trig(16'h9030, 4);
      chk("nack level", 32'h0, 32'(sda_lows - n));
      n = sda_lows;
      trig(16'h9010, 4);
      chk("ack level", 32'(4 * QTR_DEFAULT), 32'(sda_lows - n));
      rx_go <= 1'b1;
      trig(16'h9008, 3);
      rx_go <= 1'b0;
      bus(1'b0, STAT_OFFSET, 32'h0);
      chk("rx status", 32'hA5, {24'h0, rd[7:0]});
      chk("pin levels", 32'h3, {30'h0, rd[9:8]});
      chk("rx port", 32'hA5, {24'h0, rx_byte});
   endtask : t_seq
   task automatic t_idle_slave();
      chip_idle <= 1'b1;
      trig(16'h9001, 0);
      bus(1'b1, CTRL_OFFSET, 32'hB001);
      repeat (40) @(posedge hclk);
      bus(1'b0, CTRL_OFFSET, 32'h0);
      chk("idle hold", 32'h1, {31'h0, rd[0]});
      chip_idle <= 1'b0;
      wait_clr(0);
      bus(1'b1, CTRL_OFFSET, 32'h8000);
      @(posedge hclk);
      chk("stretch", 32'h0, {31'h0, scl_oe_n});
      bus(1'b1, CTRL_OFFSET, 32'h9000);
      slave_tx_start <= 1'b1;
      @(posedge hclk);
      slave_tx_start <= 1'b0;
      bus(1'b0, CTRL_OFFSET, 32'h0);
      chk("release clr", 32'h8000, rd);
   endtask : t_idle_slave
   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_seq();
      t_idle_slave();
      finish_test();
   end
endmodule : tb_two_wire_bus_control
`default_nettype wire

// [tbc_bus_model.sv]
// far-side bus device: puts one byte on the data line, msb first
// assumes pull-ups on both lines; drv_n low pulls data low
`timescale 1ns/1ps
`default_nettype none
module tbc_bus_model
#(
   parameter logic [7:0] TX_BYTE = 8'hA5
)
(
   input wire logic scl, // clock line level
   input wire logic active, // byte transfer expected
   output logic sda_drv_n // low pulls data low
);
   int rises;
   int shown;
   // count clock highs seen during the transfer
   always @(posedge scl or negedge active)
   begin
      if (!active) rises <= 0;
      else rises <= rises + 1;
   end
   // move data only while the clock is low
   always @(negedge scl or negedge active)
   begin
      if (!active) shown <= 0;
      else shown <= rises;
   end
   // released data floats to the pull-up level
   assign sda_drv_n = (active && shown < 8) ? TX_BYTE[3'(7 - shown)] : 1'b1;
endmodule : tbc_bus_model
`default_nettype wire

// [tbc_pkg.sv]
// constants shared by the two-wire bus control block
// assumes a byte-addressed ahb-lite slave holding one 16-bit control register
package tbc_pkg;
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STAT_OFFSET = 8'h04;
   localparam logic [15:0] CTRL_RESET = 16'h1000;
   localparam int BIT_ENABLE = 15;
   localparam int BIT_SIDL = 13;
   localparam int BIT_REL = 12;
   localparam int BIT_STRETCH_ENABLE = 6;
   localparam int BIT_ACK_VALUE = 5;
   localparam int BIT_ACKGO = 4;
   localparam int BIT_RCVGO = 3;
   localparam int BIT_STOPGO = 2;
   localparam int BIT_RSGO = 1;
   localparam int BIT_STARTGO = 0;
   localparam logic [15:0] CTRL_WMASK = 16'hBFFF;
   localparam logic [7:0] QTR_DEFAULT = 8'h04;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_RSTART = 3'b010,
      ST_STOP = 3'b011,
      ST_ACK = 3'b100,
      ST_RECV = 3'b101
   } tbc_state_t;
endpackage : tbc_pkg

// [tbc_top.sv]
// two-wire bus port control: ahb-lite register slave plus master sequencer
// assumes open-drain pads outside; oe low means the pin is driven low
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RL1: port runs and owns its pins only while the enable bit is set.
// RL2: with stop-in-idle set, operation pauses while the chip idles.
// RL3: slave holds clock low while release is zero; hardware clears it.
// RL4: acknowledge sequence sends the ack value bit; zero means acknowledge.
// RL5: acknowledge trigger runs the sequence and clears when it completes.
// RL6: receive trigger reads a byte and clears after the eighth bit.
// RL7: stop trigger makes a stop condition and clears at its end.
// RL8: repeated-start trigger makes a restart and clears at its end.
// RL9: start trigger makes a start condition and clears at its end.
// RL10: software issues one sequence at a time, waiting for clearing.
module tbc_top
   import tbc_pkg::*;
#(
   parameter logic [7:0] QTR = QTR_DEFAULT
)
(
   input wire logic hclk, // system clock
   input wire logic hresetn, // async reset, active low
   input wire logic hsel, // slave select
   input wire logic [7:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write strobe
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   output logic [31:0] hrdata, // read data
   input wire logic chip_idle, // chip in idle mode
   input wire logic slave_tx_start, // slave transmission begins
   input wire logic scl_in, // clock pin level
   input wire logic sda_in, // data pin level
   output logic scl_oe_n, // low drives clock low
   output logic sda_oe_n, // low drives data low
   output logic pins_owned, // pins given to the port
   output logic [7:0] rx_byte // last received byte
);
   logic [15:0] ctrl;
   tbc_state_t state;
   logic [7:0] qcnt;
   logic [1:0] phase;
   logic [3:0] bitn;
   logic scl_s1, scl_s2, sda_s1, sda_s2;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic run;
   logic tick;
   logic seq_done;

   // two-flop synchronisers for the pins
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
      end
      else
      begin
         scl_s1 <= scl_in;
         scl_s2 <= scl_s1;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
      end
   end

   // enable and idle pause gate the quarter-bit timer and sequencer; pin drive is gated by enable alone
   assign run = ctrl[BIT_ENABLE] && !(ctrl[BIT_SIDL] && chip_idle); // RL1 RL2
   assign pins_owned = ctrl[BIT_ENABLE]; // RL1
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign tick = run && (qcnt == QTR - 8'h01);
   assign seq_done = tick && (phase == 2'd3);

   // ahb address phase capture
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end
      else
      begin
         wr_pend <= hsel && hready && htrans[1] && hwrite;
         wr_addr <= haddr;
      end
   end

   // read data, registered in address phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (hsel && hready && htrans[1] && !hwrite)
      begin
         if (haddr == CTRL_OFFSET)
            hrdata <= {16'h0000, ctrl};
         else if (haddr == STAT_OFFSET)
            hrdata <= {22'h000000, sda_s2, scl_s2, rx_byte};
         else
            hrdata <= 32'h0000_0000;
      end
   end

   // control register: a software write of a one beats a hardware clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ctrl <= CTRL_RESET;
      else
      begin
         if (slave_tx_start && run)
            ctrl[BIT_REL] <= 1'b0; // RL3
         if (seq_done)
         begin
            unique case (state)
               ST_START: ctrl[BIT_STARTGO] <= 1'b0; // RL9
               ST_RSTART: ctrl[BIT_RSGO] <= 1'b0; // RL8
               ST_STOP: ctrl[BIT_STOPGO] <= 1'b0; // RL7
               ST_ACK: ctrl[BIT_ACKGO] <= 1'b0; // RL5
               ST_RECV:
               begin
                  if (bitn == 4'd7)
                     ctrl[BIT_RCVGO] <= 1'b0; // RL6
               end
               ST_IDLE: ;
            endcase
         end
         if (wr_pend && wr_addr == CTRL_OFFSET)
            ctrl <= hwdata[15:0] & CTRL_WMASK; // last, so a set is never lost
      end
   end

   // quarter-bit timer and sequencer
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= ST_IDLE;
         qcnt <= 8'h00;
         phase <= 2'd0;
         bitn <= 4'd0;
      end
      else if (!ctrl[BIT_ENABLE])
      begin
         state <= ST_IDLE;
         qcnt <= 8'h00;
         phase <= 2'd0;
         bitn <= 4'd0;
      end
      else if (run)
      begin
         if (state == ST_IDLE)
         begin
            qcnt <= 8'h00;
            phase <= 2'd0;
            bitn <= 4'd0;
            // one trigger at a time is expected; priority resolves overlap
            if (ctrl[BIT_STARTGO])
               state <= ST_START; // RL9 RL10
            else if (ctrl[BIT_RSGO])
               state <= ST_RSTART; // RL8
            else if (ctrl[BIT_STOPGO])
               state <= ST_STOP; // RL7
            else if (ctrl[BIT_ACKGO])
               state <= ST_ACK; // RL5
            else if (ctrl[BIT_RCVGO])
               state <= ST_RECV; // RL6
         end
         else
         begin
            qcnt <= tick ? 8'h00 : qcnt + 8'h01;
            if (tick)
            begin
               phase <= phase + 2'd1;
               if (phase == 2'd3)
               begin
                  if (state == ST_RECV && bitn != 4'd7)
                     bitn <= bitn + 4'd1;
                  else
                     state <= ST_IDLE;
               end
            end
         end
      end
   end

   // receive shift on the clock-high sample point
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rx_byte <= 8'h00;
      else if (state == ST_RECV && tick && phase == 2'd1)
         rx_byte <= {rx_byte[6:0], sda_s2}; // RL6
   end

   // pin drive per sequence phase; oe low pulls the line low
   always_comb
   begin
      scl_oe_n = 1'b1;
      sda_oe_n = 1'b1;
      if (ctrl[BIT_ENABLE])
      begin
         unique case (state)
            ST_START:
            begin
               sda_oe_n = (phase < 2'd2); // RL9
               scl_oe_n = (phase != 2'd3);
            end
            ST_RSTART:
            begin
               sda_oe_n = (phase < 2'd2); // RL8
               scl_oe_n = (phase == 2'd1) || (phase == 2'd2);
            end
            ST_STOP:
            begin
               sda_oe_n = (phase == 2'd3); // RL7
               scl_oe_n = (phase != 2'd0);
            end
            ST_ACK:
            begin
               sda_oe_n = ctrl[BIT_ACK_VALUE]; // RL4
               scl_oe_n = (phase == 2'd1) || (phase == 2'd2);
            end
            ST_RECV: scl_oe_n = (phase == 2'd1) || (phase == 2'd2);
            ST_IDLE: scl_oe_n = ctrl[BIT_REL]; // RL3
         endcase
      end
   end

   release_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == ST_IDLE && ctrl[BIT_ENABLE] && !ctrl[BIT_REL]) |-> !scl_oe_n) // RL3
      else $error("clock not held while release is zero");
   disabled_pins_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !ctrl[BIT_ENABLE] |-> (scl_oe_n && sda_oe_n) ##1 (state == ST_IDLE)) // RL1
      else $error("pins driven while port disabled");
   idle_pause_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ctrl[BIT_SIDL] && chip_idle && ctrl[BIT_ENABLE]) |=> $stable(qcnt)) // RL2
      else $error("timer moved during idle pause");
   ack_value_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == ST_ACK && ctrl[BIT_ENABLE]) |-> (sda_oe_n == ctrl[BIT_ACK_VALUE])) // RL4
      else $error("ack bit differs from ack value");
   ack_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == ST_ACK && seq_done && !wr_pend) |=> !ctrl[BIT_ACKGO]) // RL5
      else $error("ack trigger not cleared");
   recv_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == ST_RECV && seq_done && bitn == 4'd7 && !wr_pend)
      |=> (!ctrl[BIT_RCVGO] && state == ST_IDLE)) // RL6
      else $error("receive not ended after eighth bit");
   stop_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == ST_STOP && seq_done && !wr_pend) |=> !ctrl[BIT_STOPGO]) // RL7
      else $error("stop trigger not cleared");
   rstart_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == ST_RSTART && seq_done && !wr_pend) |=> !ctrl[BIT_RSGO]) // RL8
      else $error("restart trigger not cleared");
   start_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == ST_START && seq_done && !wr_pend) |=> !ctrl[BIT_STARTGO]) // RL9
      else $error("start trigger not cleared");
   start_c: cover property (@(posedge hclk) disable iff (!hresetn)
      state == ST_START ##1 state == ST_IDLE);
   recv_c: cover property (@(posedge hclk) disable iff (!hresetn)
      state == ST_RECV && seq_done && bitn == 4'd7);
   stop_c: cover property (@(posedge hclk) disable iff (!hresetn)
      state == ST_STOP && seq_done);
endmodule : tbc_top
`default_nettype wire
